// *** ecr_pkg.sv ***
// Overview of operation
// RULE1: seven-bit generator select at bits 22:16 picks the source of the addressed channel
// RULE2: generator select zero connects no source to the channel
// RULE3: codes 0x01-0x1B and 0x1E-0x49 are sources; 0x1C, 0x1D, 0x4A-0x7F reserved
// RULE4: reserved bits read zero; software writes them as zero
// RULE5: writing one to bit 8 injects an event on the selected channel
// RULE6: injected event travels the channel to its users like a hardware event
// RULE7: software event bit always reads back as zero
// RULE8: software sets bit 8 only in a 16-bit write carrying the channel select
// RULE9: four-bit channel select at bits 3:0 addresses channel for write or read
// RULE10: user routing at 0x08 is written in one 16-bit access with index and channel
// RULE11: an 8-bit write of the user index precedes reading that user's routing
// RULE12: user channel field 12:8 holding n+1 connects channel n; above 0xC reserved
// RULE13: user channel field zero connects no channel to the user
// RULE14: user channel field steers the user named by the index at bits 4:0
// RULE15: user index names the user a write configures or a later read returns
// RULE16: channel word written in one 32-bit access; read after 8-bit index write
// RULE17: injected event is a single-cycle pulse on the selected channel
package ecr_pkg;
   localparam int          NUM_CHANNELS   = 12;
   localparam int          NUM_USERS      = 29;
   localparam int          NUM_GENERATORS = 73;
   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [11:0] OFFSET_CONTROL = 12'h000;
   localparam logic [11:0] OFFSET_CHANNEL = 12'h004;
   localparam logic [11:0] OFFSET_USER    = 12'h008;
   localparam logic [11:0] OFFSET_STATUS  = 12'h00C;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int          SWRST_BIT      = 0;
   localparam int          CHAN_SEL_LSB   = 0;
   localparam int          SOFTWARE_EVENT_INJECT_BIT      = 8;
   localparam int          GEN_SEL_LSB    = 16;
   localparam int          PATH_LSB       = 24;
   localparam int          EDGE_LSB       = 26;
   localparam int          USER_IDX_LSB   = 0;
   localparam int          USER_CHAN_LSB  = 8;
   localparam int          STATUS_BUSY_LSB = 8;
   localparam int          STATUS_RDY_HI_LSB  = 16;
   localparam int          STATUS_BUSY_HI_LSB = 24;
   // ---------------------------------------------------------------
   // codes and reset values
   // ---------------------------------------------------------------
   localparam logic [6:0]  GEN_NONE       = 7'h00;
   localparam logic [6:0]  GEN_RSVD_LO    = 7'h1C;
   localparam logic [6:0]  GEN_RSVD_HI    = 7'h1D;
   localparam logic [6:0]  GEN_LAST       = 7'h49;
   localparam logic [4:0]  USER_CHAN_NONE = 5'h00;
   localparam logic [4:0]  USER_CHAN_LAST = 5'h0C;
   localparam logic [3:0]  RESET_CHAN_IDX = 4'h0;
   localparam logic [4:0]  RESET_USER_IDX = 5'h00;
   localparam logic [1:0]  RESET_EDGE     = 2'h0;
   localparam logic [1:0]  RESET_PATH     = 2'h0;
endpackage : ecr_pkg

// *** ecr_route_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface ecr_route_if;
   logic [11:0] channel_event;
   logic [4:0]  user_chan [29];
   logic [28:0] user_event;
   modport core (output channel_event, output user_chan, input user_event);
   modport mux  (input channel_event, input user_chan, output user_event);
endinterface : ecr_route_if
`default_nettype wire

// *** ecr_user_mux.sv ***
`timescale 1ns/100ps
`default_nettype none
module ecr_user_mux (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic swrst,
   // routing carrier
   ecr_route_if.mux  route
);
   logic [28:0] next_user_event;

   always_comb begin
      next_user_event = '0;
      for (int u = 0; u < ecr_pkg::NUM_USERS; u++) begin
         // zero and reserved codes leave the user unconnected
         if (route.user_chan[u] != ecr_pkg::USER_CHAN_NONE &&
             route.user_chan[u] <= ecr_pkg::USER_CHAN_LAST) begin // RULE13
            next_user_event[u] = route.channel_event[4'(route.user_chan[u] - 5'h01)]; // RULE12
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         route.user_event <= '0;
      end else if (swrst) begin
         route.user_event <= '0;
      end else begin
         route.user_event <= next_user_event; // RULE6
      end
   end
endmodule : ecr_user_mux
`default_nettype wire

// *** ecr_event_router.sv ***
`timescale 1ns/100ps
`default_nettype none
module ecr_event_router (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // event generators, bit c-1 carries generator code c
   input  wire logic [72:0] gen_event,
   // channel state from the edge and path stage
   input  wire logic [11:0] chan_busy,
   input  wire logic [11:0] user_ready,
   // channel and user events
   output logic [11:0]      channel_event,
   output logic [28:0]      user_event,
   // per-channel edge and path selection for the edge and path stage
   output logic [23:0]      chan_edge_sel,
   output logic [23:0]      chan_path_sel
);
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic gen_code_valid(input logic [6:0] code);
      gen_code_valid = (code != ecr_pkg::GEN_NONE) &&
                       (code != ecr_pkg::GEN_RSVD_LO) &&
                       (code != ecr_pkg::GEN_RSVD_HI) &&
                       (code <= ecr_pkg::GEN_LAST); // RULE2 RULE3
   endfunction : gen_code_valid

   // index written in this access if byte 0 is strobed, else the held one
   function automatic logic [4:0] pick_index(input logic        lane0,
                                             input logic [4:0]  written,
                                             input logic [4:0]  held);
      pick_index = lane0 ? written : held;
   endfunction : pick_index

   // top bits of the two index fields
   localparam int CHAN_HI = ecr_pkg::CHAN_SEL_LSB + 3;
   localparam int USER_HI = ecr_pkg::USER_IDX_LSB + 4;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [3:0]  chan_idx;
   logic [4:0]  user_idx;
   logic [6:0]  gen_sel   [12];
   logic [1:0]  edge_sel  [12];
   logic [1:0]  path_sel  [12];
   logic [4:0]  user_chan [29];
   logic        swrst;

   logic [3:0]  next_chan_idx;
   logic [4:0]  next_user_idx;
   logic [6:0]  next_gen_sel   [12];
   logic [1:0]  next_edge_sel  [12];
   logic [1:0]  next_path_sel  [12];
   logic [4:0]  next_user_chan [29];
   logic        next_swrst;
   logic [11:0] next_channel_event;
   logic [31:0] next_prdata;
   logic        next_pready;
   logic        next_pslverr;
   logic [23:0] next_chan_edge_sel;
   logic [23:0] next_chan_path_sel;

   logic        wr_en;
   logic        hit_ctrl;
   logic        hit_chan;
   logic        hit_user;
   logic        hit_stat;
   logic [3:0]  wr_chan;
   logic [4:0]  wr_user;
   logic [11:0] sw_inject;

   logic [31:0] chan_word;
   logic [31:0] user_word;
   logic [31:0] stat_word;

   ecr_route_if route ();

   ecr_user_mux u_user_mux (
      .pclk    (pclk),
      .presetn (presetn),
      .swrst   (swrst),
      .route   (route.mux)
   );

   // ---------------------------------------------------------------
   // apb decode
   // ---------------------------------------------------------------
   // no wait state: read data is sampled in setup, pready rises in the first access cycle
   // pready comes from a flop, so it is high in exactly one access cycle;
   // a write lands at the edge that ends that cycle and at no other
   // the full byte address is decoded: any other offset misses every
   // register and answers with an error and no effect
   assign hit_ctrl = (paddr == ecr_pkg::OFFSET_CONTROL);
   assign hit_chan = (paddr == ecr_pkg::OFFSET_CHANNEL);
   assign hit_user = (paddr == ecr_pkg::OFFSET_USER);
   assign hit_stat = (paddr == ecr_pkg::OFFSET_STATUS);
   assign wr_en    = psel && penable && pready && pwrite;
   assign wr_chan  = 4'(pick_index(pstrb[0], {1'b0, pwdata[CHAN_HI:ecr_pkg::CHAN_SEL_LSB]},
                                   {1'b0, chan_idx})); // RULE9
   assign wr_user  = pick_index(pstrb[0], pwdata[USER_HI:ecr_pkg::USER_IDX_LSB],
                                user_idx); // RULE14 RULE15

   // ---------------------------------------------------------------
   // read words
   // ---------------------------------------------------------------
   // each word starts from zero, so reserved bits can never leak a field
   always_comb begin
      chan_word = '0; // RULE4
      user_word = '0;
      stat_word = '0;
      chan_word[ecr_pkg::CHAN_SEL_LSB +: 4] = chan_idx;
      // indexes 12 to 15 hold no slot and show the index only
      if (chan_idx < 4'(ecr_pkg::NUM_CHANNELS)) begin
         // software event bit is never stored, so it reads zero
         chan_word[ecr_pkg::GEN_SEL_LSB +: 7] = gen_sel[chan_idx]; // RULE7 RULE16
         chan_word[ecr_pkg::PATH_LSB +: 2]    = path_sel[chan_idx];
         chan_word[ecr_pkg::EDGE_LSB +: 2]    = edge_sel[chan_idx];
      end
      user_word[ecr_pkg::USER_IDX_LSB +: 5] = user_idx;
      if (user_idx < 5'(ecr_pkg::NUM_USERS)) begin
         user_word[ecr_pkg::USER_CHAN_LSB +: 5] = user_chan[user_idx]; // RULE11
      end
      stat_word[7:0]                              = user_ready[7:0];
      stat_word[ecr_pkg::STATUS_BUSY_LSB +: 8]    = chan_busy[7:0];
      stat_word[ecr_pkg::STATUS_RDY_HI_LSB +: 4]  = user_ready[11:8];
      stat_word[ecr_pkg::STATUS_BUSY_HI_LSB +: 4] = chan_busy[11:8];
   end

   // ---------------------------------------------------------------
   // apb response
   // ---------------------------------------------------------------
   // read data is taken in setup, so it stands through the one access cycle
   always_comb begin
      next_pready  = psel && !penable;
      next_pslverr = psel && !penable && !(hit_ctrl || hit_chan || hit_user || hit_stat);
      next_prdata  = '0; // RULE4
      if (psel && !penable && !pwrite) begin
         if (hit_chan) begin
            next_prdata = chan_word; // RULE7
         end else if (hit_user) begin
            next_prdata = user_word; // RULE11
         end else if (hit_stat) begin
            next_prdata = stat_word;
         end
      end
   end

   // ---------------------------------------------------------------
   // configuration writes
   // ---------------------------------------------------------------
   // index registers follow lane 0 of their own register only
   always_comb begin
      next_chan_idx = chan_idx;
      next_user_idx = user_idx;
      if (wr_en && hit_chan && pstrb[0]) begin
         next_chan_idx = wr_chan; // RULE16
      end
      if (wr_en && hit_user && pstrb[0]) begin
         next_user_idx = wr_user; // RULE15
      end
   end

   // software reset request, applied one cycle after the write edge
   always_comb begin
      next_swrst = 1'b0;
      if (wr_en && hit_ctrl && pstrb[0] && pwdata[ecr_pkg::SWRST_BIT]) begin
         next_swrst = 1'b1;
      end
   end

   // channel slots; indexes 12 to 15 hold no slot, so such writes are dropped
   always_comb begin
      next_gen_sel  = gen_sel;
      next_edge_sel = edge_sel;
      next_path_sel = path_sel;
      sw_inject     = '0;
      if (wr_en && hit_chan && wr_chan < 4'(ecr_pkg::NUM_CHANNELS)) begin
         if (pstrb[2]) begin
            next_gen_sel[wr_chan] = pwdata[ecr_pkg::GEN_SEL_LSB +: 7]; // RULE1
         end
         if (pstrb[3]) begin
            next_path_sel[wr_chan] = pwdata[ecr_pkg::PATH_LSB +: 2];
            next_edge_sel[wr_chan] = pwdata[ecr_pkg::EDGE_LSB +: 2];
         end
         // the channel taken is the one carried by the same write if lane 0 is strobed, else the held chan_idx
         if (pstrb[1] && pwdata[ecr_pkg::SOFTWARE_EVENT_INJECT_BIT]) begin // RULE8
            sw_inject[wr_chan] = 1'b1; // RULE5
         end
      end
   end

   // user slots; reserved user numbers are kept as index but hold no routing
   always_comb begin
      next_user_chan = user_chan;
      if (wr_en && hit_user && pstrb[1] && wr_user < 5'(ecr_pkg::NUM_USERS)) begin
         next_user_chan[wr_user] = pwdata[ecr_pkg::USER_CHAN_LSB +: 5]; // RULE10 RULE14
      end
   end

   // ---------------------------------------------------------------
   // channel sources
   // ---------------------------------------------------------------
   always_comb begin
      next_channel_event = '0;
      next_chan_edge_sel = '0;
      next_chan_path_sel = '0;
      // levels pass through unchanged: edge detection is the next stage's job
      for (int c = 0; c < ecr_pkg::NUM_CHANNELS; c++) begin
         // empty and reserved codes leave the channel silent
         if (gen_code_valid(gen_sel[c])) begin
            next_channel_event[c] = gen_event[7'(gen_sel[c] - 7'h01)]; // RULE1
         end
         // injected event merges with the source into one pulse
         next_channel_event[c] = next_channel_event[c] | sw_inject[c]; // RULE6 RULE17
         next_chan_edge_sel[2*c +: 2] = edge_sel[c];
         next_chan_path_sel[2*c +: 2] = path_sel[c];
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= '0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         swrst   <= 1'b0;
      end else begin
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
         swrst   <= next_swrst;
      end
   end

   // software reset wins over any write in the same cycle: every group
   // below clears on it, so a write landing with it is discarded
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chan_idx <= ecr_pkg::RESET_CHAN_IDX;
         user_idx <= ecr_pkg::RESET_USER_IDX;
      end else if (swrst) begin
         chan_idx <= ecr_pkg::RESET_CHAN_IDX;
         user_idx <= ecr_pkg::RESET_USER_IDX;
      end else begin
         chan_idx <= next_chan_idx;
         user_idx <= next_user_idx;
      end
   end

   // channel slots
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int c = 0; c < ecr_pkg::NUM_CHANNELS; c++) begin
            gen_sel[c]  <= ecr_pkg::GEN_NONE;
            edge_sel[c] <= ecr_pkg::RESET_EDGE;
            path_sel[c] <= ecr_pkg::RESET_PATH;
         end
      end else if (swrst) begin
         for (int c = 0; c < ecr_pkg::NUM_CHANNELS; c++) begin
            gen_sel[c]  <= ecr_pkg::GEN_NONE;
            edge_sel[c] <= ecr_pkg::RESET_EDGE;
            path_sel[c] <= ecr_pkg::RESET_PATH;
         end
      end else begin
         gen_sel  <= next_gen_sel;
         edge_sel <= next_edge_sel;
         path_sel <= next_path_sel;
      end
   end

   // user slots
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int u = 0; u < ecr_pkg::NUM_USERS; u++) begin
            user_chan[u] <= ecr_pkg::USER_CHAN_NONE;
         end
      end else if (swrst) begin
         for (int u = 0; u < ecr_pkg::NUM_USERS; u++) begin
            user_chan[u] <= ecr_pkg::USER_CHAN_NONE;
         end
      end else begin
         user_chan <= next_user_chan;
      end
   end

   // channel outputs clear as well; one old pulse may still leave in the
   // cycle after the reset write's edge, as the request itself takes a cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         channel_event <= '0;
         chan_edge_sel <= '0;
         chan_path_sel <= '0;
      end else if (swrst) begin
         channel_event <= '0;
         chan_edge_sel <= '0;
         chan_path_sel <= '0;
      end else begin
         channel_event <= next_channel_event;
         chan_edge_sel <= next_chan_edge_sel;
         chan_path_sel <= next_chan_path_sel;
      end
   end

   // ---------------------------------------------------------------
   // routing carrier
   // ---------------------------------------------------------------
   assign route.channel_event = channel_event;
   assign route.user_chan     = user_chan;
   assign user_event          = route.user_event;
endmodule : ecr_event_router
`default_nettype wire

// *** ecr_event_router_fix_note_unused.sv ***
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// *** ecr_event_router_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module ecr_event_router_sva (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic [11:0] paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   // events
   input wire logic [72:0] gen_event,
   input wire logic [11:0] channel_event,
   input wire logic [28:0] user_event
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic rd_ch;
   logic rd_us;
   logic inj;
   assign rd_ch = pready && !pwrite && paddr == 12'h004;
   assign rd_us = pready && !pwrite && paddr == 12'h008;
   assign inj = psel && penable && pready && pwrite && paddr == 12'h004 && pstrb[1] && pwdata[8];
   property p_software_event_inject_zero; rd_ch |-> !prdata[8]; endproperty
   a_software_event_inject_zero: assert property (p_software_event_inject_zero) else $error("inject bit read as one");
   property p_ch_rsvd;
      rd_ch |-> prdata[31:28] == 4'h0 && !prdata[23] && prdata[15:9] == 7'h00 && prdata[7:4] == 4'h0;
   endproperty
   a_ch_rsvd: assert property (p_ch_rsvd) else $error("channel reserved bits set");
   property p_us_rsvd; rd_us |-> prdata[31:13] == 19'h00000 && prdata[7:5] == 3'h0; endproperty
   a_us_rsvd: assert property (p_us_rsvd) else $error("user reserved bits set");
   property p_inject; inj && pstrb[0] && pwdata[3:0] < 4'hC |=> channel_event[$past(pwdata[3:0])];
   endproperty
   a_inject: assert property (p_inject) else $error("injected event missing");
   property p_gen_quiet; !$past(inj) && $past(gen_event) == 73'h0 |-> channel_event == 12'h000;
   endproperty
   a_gen_quiet: assert property (p_gen_quiet) else $error("channel event without source");
   // codes 0x1C and 0x1D sit on bits 27 and 28 and must never reach a channel
   property p_rsvd_gen;
      !$past(inj) && ($past(gen_event) & ~(73'h3 << 27)) == 73'h0 |-> channel_event == 12'h000;
   endproperty
   a_rsvd_gen: assert property (p_rsvd_gen) else $error("reserved generator routed");
   property p_user_quiet; $past(channel_event) == 12'h000 |-> user_event == 29'h0; endproperty
   a_user_quiet: assert property (p_user_quiet) else $error("user event without channel");
   property p_pready; psel && !penable |=> pready ##1 !pready; endproperty
   a_pready: assert property (p_pready) else $error("access cycle not single");
   c_inject: cover property (inj);
   c_rd_ch: cover property (rd_ch);
   c_user: cover property (user_event != 29'h0);
endmodule : ecr_event_router_sva
bind ecr_event_router ecr_event_router_sva ecr_event_router_sva_i (.pclk(pclk), .presetn(presetn),
   .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
   .pstrb(pstrb), .prdata(prdata), .pready(pready), .gen_event(gen_event),
   .channel_event(channel_event), .user_event(user_event));
`default_nettype wire

// *** ecr_gen_user_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module ecr_gen_user_model (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // bench command
   input wire logic        fire,
   input wire logic [6:0]  fire_code,
   // routed events
   input wire logic [11:0] channel_event,
   // generator and user side
   output logic [72:0]     gen_event,
   output logic [11:0]     chan_busy,
   output logic [11:0]     user_ready
);
   logic [72:0] next_gen_event;
   // one-cycle generator pulse, so no edge logic is needed downstream
   always_comb begin
      next_gen_event = fire ? (73'h1 << (fire_code - 7'h01)) : 73'h0;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gen_event  <= 73'h0;
         chan_busy  <= 12'h000;
         user_ready <= 12'hFFF;
      end else begin
         gen_event  <= next_gen_event;
         chan_busy  <= channel_event;
         user_ready <= ~chan_busy;
      end
   end
endmodule : ecr_gen_user_model
`default_nettype wire

// *** ecr_event_router_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module ecr_event_router_tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, fire, er;
   logic [11:0] paddr, chan_busy, user_ready, channel_event;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb;
   logic [6:0]  fire_code;
   logic [72:0] gen_event;
   logic [28:0] user_event, us_seen;
   logic [23:0] chan_edge_sel, chan_path_sel;
   int          miscompares, samples_checked, cyc;
   int          ch_cnt [12];
   ecr_event_router ecr_event_router_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .gen_event(gen_event),
      .chan_busy(chan_busy), .user_ready(user_ready), .channel_event(channel_event),
      .user_event(user_event), .chan_edge_sel(chan_edge_sel), .chan_path_sel(chan_path_sel));
   ecr_gen_user_model ecr_gen_user_model_i (.pclk(pclk), .presetn(presetn), .fire(fire),
      .fire_code(fire_code), .channel_event(channel_event), .gen_event(gen_event),
      .chan_busy(chan_busy), .user_ready(user_ready));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   // ---------------------------------------------------------------
   // event counting and timeout
   // ---------------------------------------------------------------
   always @(posedge pclk) begin
      for (int i = 0; i < 12; i++) ch_cnt[i] += channel_event[i];
      us_seen = us_seen | user_event;
   end
   always @(posedge pclk) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         miscompares++;
         results();
      end
   end
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic results();
      if (miscompares == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : results
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // index goes in a one-lane write, then the register is read back
   task automatic rdx(input logic [11:0] a, input logic [7:0] idx);
      apb(1'b1, a, {24'h000000, idx}, 4'h1);
      apb(1'b0, a, 32'h00000000, 4'h0);
   endtask : rdx
   task automatic clr();
      @(negedge pclk);
      foreach (ch_cnt[i]) ch_cnt[i] = 0;
      us_seen = 29'h0;
   endtask : clr
   task automatic fire_gen(input logic [6:0] c);
      @(posedge pclk);
      fire      <= 1'b1;
      fire_code <= c;
      @(posedge pclk);
      fire <= 1'b0;
   endtask : fire_gen
   // counts per channel catch both misrouting and pulses longer than one cycle
   task automatic chkev(input logic [11:0] ech, input logic [28:0] eus);
      repeat (4) @(posedge pclk);
      for (int i = 0; i < 12; i++) chk("channel pulses", 32'(ech[i]), 32'(ch_cnt[i]));
      chk("user events", 32'(eus), 32'(us_seen));
   endtask : chkev
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      {presetn, psel, penable, pwrite, fire, er} = 6'h00;
      {paddr, pwdata, pstrb, fire_code, rd, us_seen} = '0;
      miscompares = 0;
      samples_checked = 0;
      cyc = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdx(12'h008, 8'h00); chk("user reset", 32'h00000000, rd);
      rdx(12'h004, 8'h00); chk("channel reset", 32'h00000000, rd);
      apb(1'b1, 12'h004, 32'h09050003, 4'hF);
      apb(1'b1, 12'h004, 32'h001C0004, 4'hF);
      rdx(12'h004, 8'h03); chk("channel 3", 32'h09050003, rd);
      chk("edge 3", 32'h00000002, 32'(chan_edge_sel[7:6]));
      chk("path 3", 32'h00000001, 32'(chan_path_sel[7:6]));
      apb(1'b1, 12'h008, 32'h00000506, 4'h3);
      apb(1'b1, 12'h008, 32'h00000407, 4'h3);
      apb(1'b1, 12'h008, 32'h00000D08, 4'h3);
      rdx(12'h008, 8'h06); chk("user 6", 32'h00000506, rd);
      clr(); fire_gen(7'h05); chkev(12'h008, 29'h00000080);
      clr(); fire_gen(7'h1C); chkev(12'h000, 29'h00000000);
      clr(); apb(1'b1, 12'h004, 32'h00000104, 4'h3); chkev(12'h010, 29'h00000040);
      clr(); apb(1'b1, 12'h004, 32'h00000004, 4'h3); chkev(12'h000, 29'h00000000);
      apb(1'b0, 12'h004, 32'h00000000, 4'h0); chk("channel 4", 32'h001C0004, rd);
      apb(1'b0, 12'h010, 32'h00000000, 4'h0);
      chk("unmapped error", 32'h00000001, 32'(er));
      apb(1'b0, 12'h00C, 32'h00000000, 4'h0); chk("status", 32'h000F00FF, rd);
      apb(1'b1, 12'h000, 32'h00000001, 4'h1);
      rdx(12'h008, 8'h06); chk("user 6 cleared", 32'h00000006, rd);
      clr(); fire_gen(7'h05); chkev(12'h000, 29'h00000000);
      results();
   end
endmodule : ecr_event_router_tb
`default_nettype wire
